// ### hw/rcoc_pkg.sv
// Package: constants and types for the reset and option control block
package rcoc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, APB; RCOC_PSF_IDX is the word index of RCOC_PSF_ADDR)
  // ---------------------------------------------------------------
  localparam logic [11:0] RCOC_PSF_IDX      = 12'h0086;
  localparam logic [11:0] RCOC_PSF_ADDR     = 12'h0218;
  localparam logic [11:0] RCOC_OPT_ADDR     = 12'h0400;
  localparam logic [11:0] RCOC_STAT_ADDR    = 12'h0404;
  localparam logic [11:0] RCOC_CTRL_ADDR    = 12'h0408;

  // ---------------------------------------------------------------
  // Status flag field positions
  // ---------------------------------------------------------------
  localparam int RCOC_CAUSE_HI_BIT  = 7;
  localparam int RCOC_CAUSE_LO_BIT  = 6;
  localparam int RCOC_F2V8_BIT      = 5;
  localparam int RCOC_F2V4_BIT      = 4;
  localparam logic [7:0] RCOC_PSF_RST = 8'h00;
  localparam logic [7:0] RCOC_PSF_WMASK = 8'hC7;

  // Reset cause codes in bits 7:6
  localparam logic [1:0] RCOC_CAUSE_WDT = 2'h0;
  localparam logic [1:0] RCOC_CAUSE_RSV = 2'h1;
  localparam logic [1:0] RCOC_CAUSE_POR = 2'h2;
  localparam logic [1:0] RCOC_CAUSE_EXT = 2'h3;

  // ---------------------------------------------------------------
  // Option word field positions
  // ---------------------------------------------------------------
  localparam int RCOC_OPT_DIV_LSB  = 0;   // 2 bits
  localparam int RCOC_OPT_CLK_LSB  = 2;   // 3 bits
  localparam int RCOC_OPT_WDT_LSB  = 5;   // 2 bits
  localparam int RCOC_OPT_RPIN_BIT = 7;
  localparam int RCOC_OPT_LV_LSB   = 8;   // 2 bits
  localparam int RCOC_OPT_SEC_BIT  = 10;

  typedef enum logic [2:0] {
    RCOC_CLK_IRC8M  = 3'h0,
    RCOC_CLK_IRCTK  = 3'h1,
    RCOC_CLK_EXTRC  = 3'h2,
    RCOC_CLK_X32K   = 3'h3,
    RCOC_CLK_X8M    = 3'h4,
    RCOC_CLK_X4M    = 3'h5
  } rcoc_clk_t;

  typedef enum logic [1:0] {
    RCOC_WDT_ALWAYS = 2'h0,
    RCOC_WDT_ENABLE = 2'h1,
    RCOC_WDT_OFF    = 2'h2
  } rcoc_wdt_t;

  typedef enum logic [1:0] {
    RCOC_LV_LOW  = 2'h0,
    RCOC_LV_MID  = 2'h1,
    RCOC_LV_HIGH = 2'h2
  } rcoc_lv_t;

  // ---------------------------------------------------------------
  // Sequencer states, gray along power-up path
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RCOC_ST_PWRUP = 3'b000,
    RCOC_ST_EXTW  = 3'b001,
    RCOC_ST_INIT  = 3'b011,
    RCOC_ST_WARM  = 3'b010,
    RCOC_ST_RUN   = 3'b110
  } rcoc_state_t;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int RCOC_CLK_MHZ        = 250;
  localparam int RCOC_STABLE_NS      = 1000;
  localparam int RCOC_STABLE_CYC     = (RCOC_STABLE_NS * RCOC_CLK_MHZ + 999) / 1000;
  localparam int RCOC_WARM_RC_NS     = 512;
  localparam int RCOC_WARM_RC_CYC    = (RCOC_WARM_RC_NS * RCOC_CLK_MHZ + 999) / 1000;
  localparam int RCOC_WARM_XT_NS     = 16000;
  localparam int RCOC_WARM_XT_CYC    = (RCOC_WARM_XT_NS * RCOC_CLK_MHZ + 999) / 1000;
  localparam int RCOC_TICK_MS        = 500;
  localparam int RCOC_TICK_CYC       = RCOC_TICK_MS * RCOC_CLK_MHZ * 1000;
  localparam logic [16:0] RCOC_CNT_ZERO = 17'h0_0000;

endpackage : rcoc_pkg

// ### hw/rcoc_top.sv
// Reset sources, power-up sequencer, option decode and status flags
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module rcoc_top
  import rcoc_pkg::*;
#(
  parameter int STABLE_CYC  = RCOC_STABLE_CYC,
  parameter int WARM_XT_CYC = RCOC_WARM_XT_CYC,
  parameter int TICK_CYC    = RCOC_TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [10:0] option_word,
  input  wire logic        supply_ok,
  input  wire logic        below_1v8,
  input  wire logic        below_2v4,
  input  wire logic        below_2v8,
  input  wire logic        wdt_overflow,
  input  wire logic        sleep_mode,
  input  wire logic        rst_pin,
  input  wire logic        hosc_en,
  output logic             cpu_clk_en,
  output logic             cpu_rst_n,
  output logic             pc_clear,
  output logic [12:0]      boot_addr,
  output logic             wdt_run,
  output logic             osc_in_pin_gpio,
  output logic             osc_out_pin_gpio,
  output logic             port0_bit2_input,
  output logic             rst_pin_pullup,
  output logic             tick_pulse,
  output logic             rom_read_block
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    rcoc_state_t st;
    logic [16:0] cnt;
    logic [31:0] tick_cnt;
    logic [2:0]  div_cnt;
    logic [7:0]  psf;
    logic [10:0] opt;
    logic [1:0]  s_sup;
    logic [1:0]  s_18;
    logic [1:0]  s_24;
    logic [1:0]  s_28;
    logic [1:0]  s_wdt;
    logic [1:0]  s_pin;
    logic        pin_d;
    logic        clk_en;
    logic        tick;
    logic        run;
    logic [31:0] rdata;
  } rcoc_reg_t;

  rcoc_reg_t r_r;
  rcoc_reg_t r_nxt;

  // Option field decode, used by several paths
  function automatic rcoc_clk_t clk_sel(input logic [10:0] o);
    clk_sel = rcoc_clk_t'(o[RCOC_OPT_CLK_LSB +: 3]);
  endfunction

  function automatic logic is_crystal(input logic [10:0] o);
    is_crystal = (clk_sel(o) == RCOC_CLK_X32K) || (clk_sel(o) == RCOC_CLK_X8M) ||
                 (clk_sel(o) == RCOC_CLK_X4M);
  endfunction

  logic       ext_en;
  rcoc_lv_t   lv_opt;
  rcoc_wdt_t  wdt_opt;
  logic       lv_rst;
  logic       pin_fall;
  logic       any_rst;
  logic       psf_sel;
  logic       opt_sel;
  logic       stat_sel;
  logic [16:0] warm_cyc;

  assign ext_en  = r_r.opt[RCOC_OPT_RPIN_BIT] == 1'b0;
  assign lv_opt  = rcoc_lv_t'(r_r.opt[RCOC_OPT_LV_LSB +: 2]);
  assign wdt_opt = rcoc_wdt_t'(r_r.opt[RCOC_OPT_WDT_LSB +: 2]);
  // Threshold is chosen by latched option level
  assign lv_rst  = r_r.s_18[1] || ((lv_opt == RCOC_LV_HIGH) && r_r.s_24[1]);
  assign pin_fall = ext_en && r_r.pin_d && !r_r.s_pin[1];
  assign any_rst = lv_rst || !r_r.s_sup[1] || (r_r.s_wdt[1] && wdt_run) || pin_fall;
  assign warm_cyc = is_crystal(r_r.opt) ? 17'(WARM_XT_CYC) : 17'(RCOC_WARM_RC_CYC);
  assign psf_sel  = paddr == RCOC_PSF_ADDR;
  assign opt_sel  = paddr == RCOC_OPT_ADDR;
  assign stat_sel = paddr == RCOC_STAT_ADDR;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    r_nxt = r_r;
    // Only the second stage is ever read
    r_nxt.s_sup = {r_r.s_sup[0], supply_ok};
    r_nxt.s_18  = {r_r.s_18[0], below_1v8};
    r_nxt.s_24  = {r_r.s_24[0], below_2v4};
    r_nxt.s_28  = {r_r.s_28[0], below_2v8};
    r_nxt.s_wdt = {r_r.s_wdt[0], wdt_overflow};
    r_nxt.s_pin = {r_r.s_pin[0], rst_pin};
    r_nxt.pin_d = r_r.s_pin[1];
    r_nxt.tick  = 1'b0;
    r_nxt.clk_en = 1'b0;
    // Divider
    if (hosc_en && r_r.run) begin
      r_nxt.div_cnt = r_r.div_cnt + 3'h1;
      unique case (r_r.opt[RCOC_OPT_DIV_LSB +: 2])
        2'h0: r_nxt.clk_en = 1'b1;
        2'h1: r_nxt.clk_en = r_r.div_cnt[0];
        2'h2: r_nxt.clk_en = &r_r.div_cnt[1:0];
        2'h3: r_nxt.clk_en = &r_r.div_cnt;
      endcase
    end
    // Half-second tick only for internal RC with timekeeping
    if (clk_sel(r_r.opt) == RCOC_CLK_IRCTK) begin
      if (r_r.tick_cnt == 32'(TICK_CYC - 1)) begin
        r_nxt.tick_cnt = 32'h0000_0000;
        r_nxt.tick = 1'b1;
      end else begin
        r_nxt.tick_cnt = r_r.tick_cnt + 32'h0000_0001;
      end
    end
    // Indicator flags follow supply when enabled by option
    r_nxt.psf[RCOC_F2V4_BIT] = (lv_opt != RCOC_LV_LOW) && r_r.s_24[1];
    r_nxt.psf[RCOC_F2V8_BIT] = (lv_opt == RCOC_LV_HIGH) && r_r.s_28[1];
    // Sequencer
    unique case (r_r.st)
      RCOC_ST_PWRUP: begin
        r_nxt.run = 1'b0;
        if (!r_r.s_sup[1]) begin
          r_nxt.cnt = RCOC_CNT_ZERO;
        end else if (r_r.cnt == 17'(STABLE_CYC - 1)) begin
          r_nxt.cnt = RCOC_CNT_ZERO;
          r_nxt.st  = RCOC_ST_EXTW;
        end else begin
          r_nxt.cnt = r_r.cnt + 17'h0_0001;
        end
      end
      RCOC_ST_EXTW: begin
        if (!ext_en || r_r.s_pin[1]) r_nxt.st = RCOC_ST_INIT;
      end
      RCOC_ST_INIT: begin
        r_nxt.psf[2:0] = 3'h0;
        r_nxt.st = RCOC_ST_WARM;
      end
      RCOC_ST_WARM: begin
        if (r_r.cnt >= warm_cyc - 17'h0_0001) begin
          r_nxt.cnt = RCOC_CNT_ZERO;
          r_nxt.st  = RCOC_ST_RUN;
          r_nxt.run = 1'b1;
        end else begin
          r_nxt.cnt = r_r.cnt + 17'h0_0001;
        end
      end
      RCOC_ST_RUN: begin
        if (psel && penable && pwrite && psf_sel) begin
          r_nxt.psf = (r_r.psf & ~RCOC_PSF_WMASK) | (pwdata[7:0] & RCOC_PSF_WMASK);
          r_nxt.psf[RCOC_F2V4_BIT] = (lv_opt != RCOC_LV_LOW) && r_r.s_24[1];
          r_nxt.psf[RCOC_F2V8_BIT] = (lv_opt == RCOC_LV_HIGH) && r_r.s_28[1];
        end
      end
      default: r_nxt.st = RCOC_ST_PWRUP;
    endcase
    // Any reset source restarts the sequence and records its cause;
    // evaluated every reset cycle so power-on latches options and cause too
    if (any_rst) begin
      r_nxt.st  = RCOC_ST_PWRUP;
      r_nxt.cnt = RCOC_CNT_ZERO;
      r_nxt.run = 1'b0;
      r_nxt.div_cnt = 3'h0;
      r_nxt.psf[2:0] = 3'h0;
      // Options are sampled only here, never in operation
      r_nxt.opt = option_word;
      if (lv_rst || !r_r.s_sup[1]) begin
        r_nxt.psf[7:6] = RCOC_CAUSE_POR;
        r_nxt.psf[5:4] = 2'h0;
      end else if (pin_fall) begin
        r_nxt.psf[7:6] = RCOC_CAUSE_EXT;
      end else begin
        r_nxt.psf[7:6] = RCOC_CAUSE_WDT;
      end
    end
    // APB read data, registered in setup and held until the next read setup
    if (psel && !penable && !pwrite) begin
      r_nxt.rdata = 32'h0000_0000;
      if (psf_sel)  r_nxt.rdata = {24'h00_0000, r_r.psf};
      if (opt_sel)  r_nxt.rdata = {21'h00_0000, r_r.opt};
      if (stat_sel) r_nxt.rdata = {27'h000_0000, r_r.run, r_r.st, ext_en};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '{st: RCOC_ST_PWRUP, psf: RCOC_PSF_RST, default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Single-cycle access; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(psf_sel || opt_sel || stat_sel);
  assign prdata  = r_r.rdata;

  assign cpu_clk_en = r_r.clk_en;
  assign cpu_rst_n  = r_r.run;
  assign pc_clear   = !r_r.run;
  assign boot_addr  = 13'h0000;
  // Gating from latched options
  assign wdt_run = r_r.run && ((wdt_opt == RCOC_WDT_ALWAYS) ||
                   ((wdt_opt == RCOC_WDT_ENABLE) && !sleep_mode));
  assign osc_in_pin_gpio  = (clk_sel(r_r.opt) == RCOC_CLK_IRC8M) ||
                            (clk_sel(r_r.opt) == RCOC_CLK_IRCTK);
  assign osc_out_pin_gpio = osc_in_pin_gpio ||
                            (clk_sel(r_r.opt) == RCOC_CLK_EXTRC);
  assign port0_bit2_input = !ext_en && r_r.s_pin[1];
  assign rst_pin_pullup   = ext_en;
  assign tick_pulse       = r_r.tick;
  assign rom_read_block   = r_r.opt[RCOC_OPT_SEC_BIT];

endmodule // rcoc_top
`default_nettype wire

// ### testbench/rcoc_checker.sv
// Checker: port-level assertions for the reset and option block
`timescale 1ns/1ns
`default_nettype none
module rcoc_checker
  import rcoc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [10:0] option_word,
  input wire logic        below_1v8,
  input wire logic        sleep_mode,
  input wire logic        rst_pin,
  input wire logic        cpu_rst_n,
  input wire logic        pc_clear,
  input wire logic [12:0] boot_addr,
  input wire logic        wdt_run,
  input wire logic        osc_in_pin_gpio,
  input wire logic        osc_out_pin_gpio,
  input wire logic        rst_pin_pullup,
  input wire logic        tick_pulse,
  input wire logic        rom_read_block
);
  logic [2:0] csel;
  logic [1:0] wsel;
  assign csel = option_word[4:2];
  assign wsel = option_word[6:5];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_boot_zero: assert property (boot_addr == 13'h0000)
    else $error("boot address not zero");
  a_pc_held: assert property (pc_clear == !cpu_rst_n)
    else $error("pc clear not tied to reset");
  a_wdt_always: assert property (cpu_rst_n && wsel == 2'h0 |-> wdt_run)
    else $error("always-on watchdog stopped");
  a_wdt_sleep: assert property (cpu_rst_n && wsel == 2'h1 && sleep_mode == $past(sleep_mode)
    |-> wdt_run == !sleep_mode)
    else $error("watchdog sleep gating wrong");
  a_wdt_off: assert property (cpu_rst_n && wsel == 2'h2 |-> !wdt_run)
    else $error("disabled watchdog running");
  a_osc_pins: assert property (cpu_rst_n |-> osc_in_pin_gpio == (csel <= 3'h1)
    && osc_out_pin_gpio == (csel <= 3'h2))
    else $error("oscillator pin release wrong");
  a_pin_nopull: assert property (cpu_rst_n && option_word[7] |-> !rst_pin_pullup)
    else $error("pull-up on input pin");
  a_rom_guard: assert property (cpu_rst_n |-> rom_read_block == option_word[10])
    else $error("rom guard mismatch");
  a_pin_reset: assert property (cpu_rst_n && !option_word[7] && $fell(rst_pin)
    |-> ##[1:8] !cpu_rst_n)
    else $error("pin edge gave no reset");
  a_lv_reset: assert property (cpu_rst_n && below_1v8 |-> ##[1:8] !cpu_rst_n)
    else $error("low supply gave no reset");
  a_tick_only: assert property (cpu_rst_n && csel != 3'h1 |-> !tick_pulse)
    else $error("tick without tick option");
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("access not answered");
  c_boot: cover property ($rose(cpu_rst_n));
  c_sleep: cover property (cpu_rst_n && wsel == 2'h1 && sleep_mode);
  c_tick: cover property (tick_pulse);
  c_err: cover property (psel && penable && pslverr);
endmodule // rcoc_checker
bind rcoc_top rcoc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .option_word(option_word),
  .below_1v8(below_1v8), .sleep_mode(sleep_mode), .rst_pin(rst_pin),
  .cpu_rst_n(cpu_rst_n), .pc_clear(pc_clear), .boot_addr(boot_addr), .wdt_run(wdt_run),
  .osc_in_pin_gpio(osc_in_pin_gpio), .osc_out_pin_gpio(osc_out_pin_gpio),
  .rst_pin_pullup(rst_pin_pullup), .tick_pulse(tick_pulse),
  .rom_read_block(rom_read_block));
`default_nettype wire

// ### testbench/rcoc_env.sv
// Far-side model: supply monitor, reset pin, oscillator, watchdog
`timescale 1ns/1ns
`default_nettype none
module rcoc_env (
  input  wire logic clk,
  output logic      supply_ok,
  output logic      below_1v8,
  output logic      below_2v4,
  output logic      below_2v8,
  output logic      wdt_overflow,
  output logic      rst_pin,
  output logic      hosc_en
);
  initial begin
    supply_ok = 1'b0;
    {below_1v8, below_2v4, below_2v8} = 3'b111;
    wdt_overflow = 1'b0;
    rst_pin = 1'b1;
    hosc_en = 1'b1;
  end
  // Comparators follow one supply level, so they never disagree
  task automatic set_mv(input int mv);
    @(posedge clk);
    supply_ok <= mv >= 1800;
    below_1v8 <= mv < 1800;
    below_2v4 <= mv <= 2400;
    below_2v8 <= mv <= 2800;
  endtask
  // Pin release is the outside party's choice
  task automatic pin(input logic v);
    @(posedge clk);
    rst_pin <= v;
  endtask
  // Held three cycles so the two-flop sync sees it
  task automatic wdog;
    @(posedge clk);
    wdt_overflow <= 1'b1;
    repeat (3) @(posedge clk);
    wdt_overflow <= 1'b0;
  endtask
endmodule // rcoc_env
`default_nettype wire

// ### testbench/rcoc_top_tb.sv
// Testbench: reset sequencing, option decode and status flags
`timescale 1ns/1ns
`default_nettype none
module rcoc_top_tb;
  import rcoc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_mode;
  logic        cpu_clk_en, cpu_rst_n, pc_clear, wdt_run, gin, gout, p02, pull, tick, romb;
  logic        sok, b18, b24, b28, wov, rpin, hosc, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] option_word, o;
  logic [12:0] boot_addr;
  logic [7:0]  rnd;
  int          mismatches, checked, n, c;
  rcoc_env env (.clk(pclk), .supply_ok(sok), .below_1v8(b18), .below_2v4(b24),
    .below_2v8(b28), .wdt_overflow(wov), .rst_pin(rpin), .hosc_en(hosc));
  rcoc_top #(.STABLE_CYC(4), .WARM_XT_CYC(8), .TICK_CYC(16)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .option_word(option_word), .supply_ok(sok), .below_1v8(b18), .below_2v4(b24),
    .below_2v8(b28), .wdt_overflow(wov), .sleep_mode(sleep_mode), .rst_pin(rpin),
    .hosc_en(hosc), .cpu_clk_en(cpu_clk_en), .cpu_rst_n(cpu_rst_n), .pc_clear(pc_clear),
    .boot_addr(boot_addr), .wdt_run(wdt_run), .osc_in_pin_gpio(gin),
    .osc_out_pin_gpio(gout), .port0_bit2_input(p02), .rst_pin_pullup(pull),
    .tick_pulse(tick), .rom_read_block(romb));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ok(input string nm, input logic cond);
    check(nm, {31'h0, cond}, 32'h1);
  endtask
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic flags(input logic [7:0] e);
    apb(1'b0, RCOC_PSF_ADDR, 32'h0000_0000);
    check("flags", rd, {24'h0, e});
  endtask
  task automatic run_wait;
    n = 0;
    while (cpu_rst_n !== 1'b1 && n < 2000) begin
      @(negedge pclk);
      n++;
    end
    ok("boot", cpu_rst_n === 1'b1);
  endtask
  task automatic rst_wait;
    repeat (10) @(negedge pclk);
    ok("reset", cpu_rst_n === 1'b0);
    run_wait;
  endtask
  task automatic pwr_on(input logic [10:0] v);
    env.set_mv(0);
    repeat (4) @(posedge pclk);
    option_word <= v;
    env.set_mv(3300);
  endtask
  task automatic count(ref logic s);
    c = 0;
    repeat (64) begin
      @(negedge pclk);
      if (s === 1'b1) c++;
    end
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(negedge pclk);
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #80000;
    mismatches++;
    complete_run;
  end
  initial begin
    {mismatches, checked, rnd} = {32'd0, 32'd0, 8'h33};
    {presetn, psel, penable, pwrite, paddr, pwdata, sleep_mode} = '0;
    option_word = 11'h000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // RC clock, always-on watchdog, reset pin, low level
    rnd = lfsr(rnd);
    o = {rnd[2], 2'h0, 1'b0, 2'h0, 3'h0, rnd[1:0]};
    pwr_on(o);
    run_wait;
    ok("startup rc", n >= 131 && n <= 139);
    flags({RCOC_CAUSE_POR, 6'h00});
    count(cpu_clk_en);
    ok("cpu clock", c >= (64 >> o[1:0]) - 1 && c <= (64 >> o[1:0]) + 1);
    rnd = lfsr(rnd);
    apb(1'b1, RCOC_PSF_ADDR, {24'h0, rnd});
    env.set_mv(2000);
    wait_cyc(6);
    flags({rnd[7:6], 3'h0, rnd[2:0]});
    env.set_mv(3300);
    env.wdog;
    rst_wait;
    flags({RCOC_CAUSE_WDT, 6'h00});
    env.pin(1'b0);
    env.pin(1'b1);
    rst_wait;
    flags({RCOC_CAUSE_EXT, 6'h00});
    // Crystal, watchdog off, pin as input, mid level
    o = {1'b0, 2'h1, 1'b1, 2'h2, 3'h4, 2'h0};
    env.pin(1'b0);
    pwr_on(o);
    run_wait;
    ok("startup xtal", n >= 11 && n <= 19);
    ok("pin low", p02 === 1'b0);
    env.pin(1'b1);
    wait_cyc(4);
    ok("pin high", p02 === 1'b1);
    env.pin(1'b0);
    env.wdog;
    wait_cyc(8);
    ok("no reset", cpu_rst_n === 1'b1);
    env.set_mv(2000);
    wait_cyc(6);
    flags({RCOC_CAUSE_POR, 6'h10});
    apb(1'b0, RCOC_OPT_ADDR, 32'h0000_0000);
    check("options", rd, {21'h0, o});
    apb(1'b0, RCOC_CTRL_ADDR, 32'h0000_0000);
    ok("unmapped", err === 1'b1);
    env.set_mv(1700);
    wait_cyc(8);
    ok("lv reset", cpu_rst_n === 1'b0);
    env.set_mv(3300);
    run_wait;
    flags({RCOC_CAUSE_POR, 6'h00});
    // Tick clock, watchdog with sleep stop, reset pin held, high level
    o = {1'b1, 2'h2, 1'b0, 2'h1, 3'h1, 2'h3};
    pwr_on(o);
    wait_cyc(200);
    ok("pin hold", cpu_rst_n === 1'b0);
    env.pin(1'b1);
    run_wait;
    @(posedge pclk);
    sleep_mode <= 1'b1;
    wait_cyc(4);
    ok("wdt sleep", wdt_run === 1'b0);
    sleep_mode <= 1'b0;
    count(tick);
    ok("tick", c >= 3 && c <= 5);
    env.set_mv(2600);
    wait_cyc(6);
    flags({RCOC_CAUSE_POR, 6'h20});
    env.set_mv(2200);
    wait_cyc(8);
    ok("2v4 reset", cpu_rst_n === 1'b0);
    env.set_mv(3300);
    run_wait;
    flags({RCOC_CAUSE_POR, 6'h00});
    complete_run;
  end
endmodule // rcoc_top_tb
`default_nettype wire
